// >>> hdl/adcp_top.sv
// converter control: registers, sequencer and compare stage
`timescale 1ns/1ns
`default_nettype none
`include "adcp_defs.svh"
module adcp_top
	import adcp_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// internal bus
	input  wire logic [15:0] bus_addr,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	input  wire logic [7:0]  bus_wdata,
	output logic [7:0]       bus_rdata,
	// power state
	input  wire logic        standby,
	// analog front end
	input  wire logic        cmp_above,
	output logic [2:0]       analog_sel,
	output logic             sample_hold,
	output logic [7:0]       trial_code,
	// interrupt
	output logic             conversion_irq
);
	typedef struct packed
	{
		logic [7:0] converter_mode_reg;
		logic [7:0] channel_select_reg;
		logic [7:0] compare_mode_reg;
		logic [7:0] threshold_reg;
		logic [7:0] rdata;
		logic [2:0] sel;
		logic       sh;
		logic [7:0] code;
		logic       irq;
	} adcp_top_s;

	adcp_top_s   st;
	adcp_top_s   next_st;
	logic        wr_mode;
	logic        wr_chan;
	logic        cfg_write;
	logic [7:0]  result;
	logic        res_irq;
	logic        seq_sh;
	logic [7:0]  seq_code;
	adcp_conv_if conv ();

	// write decode
	assign wr_mode   = bus_wr && (bus_addr == `ADCP_OFS_MODE);
	assign wr_chan   = bus_wr && (bus_addr == `ADCP_OFS_CHAN);
	assign cfg_write = wr_mode || wr_chan;

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		if (wr_mode)
			next_st.converter_mode_reg = bus_wdata;
		if (wr_chan)
			next_st.channel_select_reg = bus_wdata;
		if (bus_wr && bus_addr == `ADCP_OFS_CMPMODE)
			next_st.compare_mode_reg = bus_wdata;
		if (bus_wr && bus_addr == `ADCP_OFS_THRESH)
			next_st.threshold_reg = bus_wdata;
		// old value read; result updates the cycle after
		unique case (bus_addr)
			`ADCP_OFS_MODE:    next_st.rdata = st.converter_mode_reg;
			`ADCP_OFS_CHAN:    next_st.rdata = st.channel_select_reg;
			`ADCP_OFS_CMPMODE: next_st.rdata = st.compare_mode_reg;
			`ADCP_OFS_THRESH:  next_st.rdata = st.threshold_reg;
			`ADCP_OFS_RESULT:  next_st.rdata = result;
			default:           next_st.rdata = 8'h00;
		endcase
		if (!bus_rd)
			next_st.rdata = st.rdata;
		// prohibited channel codes simply pass through; software keeps them out
		next_st.sel  = st.channel_select_reg[`ADCP_CHAN_MSB:0];
		next_st.sh   = seq_sh;
		next_st.code = seq_code;
		next_st.irq  = res_irq;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			st <= '{`ADCP_RST_BYTE, `ADCP_RST_BYTE, `ADCP_RST_BYTE, `ADCP_RST_BYTE,
				8'h00, 3'h0, 1'b0, 8'h00, 1'b0};
		else
			st <= next_st;
	end

	// ------------------------------------------------------------
	// conversion path
	// ------------------------------------------------------------
	// standby stop
	adcp_sar u_sar
	(
		.clk         (clk),
		.nrst        (nrst),
		.run         (st.converter_mode_reg[`ADCP_MODE_RUN_BIT]),
		.restart     (cfg_write),
		.standby     (standby),
		.cmp_above   (cmp_above),
		.sample_hold (seq_sh),
		.trial_code  (seq_code),
		.conv        (conv.seq)
	);

	adcp_result u_res
	(
		.clk       (clk),
		.nrst      (nrst),
		.cmp_en    (st.compare_mode_reg[`ADCP_CMP_EN_BIT]),
		.cmp_pol   (st.compare_mode_reg[`ADCP_CMP_POL_BIT]),
		.threshold (st.threshold_reg),
		.cfg_write (cfg_write),
		.conv      (conv.res),
		.result    (result),
		.irq       (res_irq)
	);

	assign bus_rdata      = st.rdata;
	assign analog_sel     = st.sel;
	assign sample_hold    = st.sh;
	assign trial_code     = st.code;
	assign conversion_irq = st.irq;
endmodule
`default_nettype wire

// >>> hdl/adcp_defs.svh
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCP_DEFS_SVH
`define ADCP_DEFS_SVH

`define ADCP_ADDR_W          16
`define ADCP_OFS_MODE        16'hff98
`define ADCP_OFS_CHAN        16'hff99
`define ADCP_OFS_CMPMODE     16'hff9a
`define ADCP_OFS_THRESH      16'hff9b
`define ADCP_OFS_RESULT      16'hff9c
`define ADCP_RST_BYTE        8'h00
`define ADCP_MODE_RUN_BIT    7
`define ADCP_MODE_TIME_HI    4
`define ADCP_MODE_TIME_LO    2
`define ADCP_CMP_EN_BIT      7
`define ADCP_CMP_POL_BIT     6
`define ADCP_CHAN_MSB        2
`define ADCP_CHAN_LAST       3'h4
`define ADCP_SAMPLE_CYC      8'h10
`define ADCP_BIT_CYC         8'h10

`endif

// >>> hdl/adcp_pkg.sv
// types shared by the converter control modules
package adcp_pkg;
	typedef enum logic [1:0]
	{
		ADCP_IDLE   = 2'b00,
		ADCP_SAMPLE = 2'b01,
		ADCP_RESOLVE = 2'b10
	} adcp_state_e;
endpackage

// >>> hdl/adcp_conv_if.sv
// signals between the sequencer and the result/compare stage
`timescale 1ns/1ns
`default_nettype none
interface adcp_conv_if;
	logic       done;
	logic [7:0] value;
	logic       first;
	modport seq (output done, output value, output first);
	modport res (input done, input value, input first);
endinterface
`default_nettype wire

// >>> hdl/adcp_sar.sv
// successive approximation sequencer: sample, hold, resolve eight bits msb first
`timescale 1ns/1ns
`default_nettype none
`include "adcp_defs.svh"
module adcp_sar
	import adcp_pkg::*;
(
	// clock and reset
	input  wire logic  clk,
	input  wire logic  nrst,
	// control
	input  wire logic  run,
	input  wire logic  restart,
	input  wire logic  standby,
	// analog front end
	input  wire logic  cmp_above,
	output logic       sample_hold,
	output logic [7:0] trial_code,
	// result
	adcp_conv_if.seq   conv
);
	typedef struct packed
	{
		adcp_state_e state;
		logic [7:0]  sar;
		logic [2:0]  bit_idx;
		logic [7:0]  cnt;
		logic        done;
		logic        first;
		logic        was_run;
	} adcp_sar_s;

	adcp_sar_s st;
	adcp_sar_s next_st;

	// sequencer: any restart or stop drops the conversion in flight
	always_comb
	begin
		next_st = st;
		next_st.done = 1'b0;
		next_st.was_run = run;
		if (!run || restart || standby)
			next_st.state = ADCP_IDLE;
		unique case (st.state)
			ADCP_IDLE:
			begin
				if (run && !standby)
				begin
					next_st.state = ADCP_SAMPLE;
					next_st.cnt = `ADCP_SAMPLE_CYC;
					next_st.sar = 8'h80;
					next_st.bit_idx = 3'h7;
				end
				if (run && !st.was_run)
					next_st.first = 1'b1;
			end
			ADCP_SAMPLE:
			begin
				if (st.cnt == 8'h01 && run && !restart && !standby)
				begin
					next_st.state = ADCP_RESOLVE;
					next_st.cnt = `ADCP_BIT_CYC;
				end
				else
					next_st.cnt = st.cnt - 8'h01;
			end
			ADCP_RESOLVE:
			begin
				if (st.cnt != 8'h01)
					next_st.cnt = st.cnt - 8'h01;
				else if (run && !restart && !standby)
				begin
					next_st.sar[st.bit_idx] = cmp_above;
					next_st.cnt = `ADCP_BIT_CYC;
					if (st.bit_idx != 3'h0)
					begin
						next_st.sar[st.bit_idx - 3'h1] = 1'b1;
						next_st.bit_idx = st.bit_idx - 3'h1;
					end
					else
					begin
						next_st.done = 1'b1;
						next_st.state = ADCP_SAMPLE;
						next_st.cnt = `ADCP_SAMPLE_CYC;
					end
				end
			end
		endcase
		if (st.done)
		begin
			next_st.first = 1'b0;
			next_st.sar = 8'h80;
			next_st.bit_idx = 3'h7;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			st <= '{ADCP_IDLE, 8'h80, 3'h7, 8'h00, 1'b0, 1'b0, 1'b0};
		else
			st <= next_st;
	end

	assign sample_hold = (st.state == ADCP_SAMPLE);
	assign trial_code  = st.sar;
	assign conv.done   = st.done;
	assign conv.value  = st.sar;
	assign conv.first  = st.first;
endmodule
`default_nettype wire

// >>> hdl/adcp_result.sv
// result latch for each finished conversion, compare decision for each but the first after run, except one whose end meets a mode or channel write
`timescale 1ns/1ns
`default_nettype none
`include "adcp_defs.svh"
module adcp_result
	import adcp_pkg::*;
(
	// clock and reset
	input  wire logic  clk,
	input  wire logic  nrst,
	// settings
	input  wire logic  cmp_en,
	input  wire logic  cmp_pol,
	input  wire logic [7:0] threshold,
	input  wire logic  cfg_write,
	// from sequencer
	adcp_conv_if.res   conv,
	// out
	output logic [7:0] result,
	output logic       irq
);
	typedef struct packed
	{
		logic [7:0] result;
		logic       irq;
	} adcp_res_s;

	adcp_res_s st;
	adcp_res_s next_st;
	logic      hit;

	always_comb
	begin
		next_st = st;
		next_st.irq = 1'b0;
		hit = cmp_pol ? (conv.value < threshold) : (conv.value >= threshold);
		if (conv.done && !cfg_write)
		begin
			next_st.result = conv.value;
			next_st.irq = cmp_en ? (hit && !conv.first) : 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			st <= '{`ADCP_RST_BYTE, 1'b0};
		else
			st <= next_st;
	end

	assign result = st.result;
	assign irq    = st.irq;
endmodule
`default_nettype wire

// >>> tb/adcp_top_chk.sv
// port assertions for the converter control
`timescale 1ns/1ns
`default_nettype none
module adcp_top_chk
(
	// clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// register bus
	input wire logic [15:0] bus_addr,
	input wire logic        bus_wr,
	input wire logic        bus_rd,
	input wire logic [7:0]  bus_wdata,
	input wire logic [7:0]  bus_rdata,
	// converter side
	input wire logic        standby,
	input wire logic [2:0]  analog_sel,
	input wire logic        sample_hold,
	input wire logic [7:0]  trial_code,
	input wire logic        conversion_irq
);
	// ----------------------------------------
	// checks, all in the one clock domain
	// ----------------------------------------
	// mode or channel write: restarts or halts the sequencer
	logic cfg_wr;
	assign cfg_wr = bus_wr && (bus_addr == 16'hff98 || bus_addr == 16'hff99);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_pulse;
		conversion_irq |=> !conversion_irq;
	endproperty
	a_pulse: assert property (p_pulse) else $error("irq wider than one cycle");
	property p_chan;
		bus_wr && bus_addr == 16'hff99 |-> ##2 analog_sel == $past(bus_wdata[2:0], 2);
	endproperty
	a_chan: assert property (p_chan) else $error("channel select not applied");
	property p_halt;
		bus_wr && bus_addr == 16'hff98 && !bus_wdata[7] |-> ##2 (!conversion_irq [*8]);
	endproperty
	a_halt: assert property (p_halt) else $error("irq after halt");
	// a write racing a conversion end must swallow that end's irq, two stages later
	property p_drop;
		cfg_wr |-> ##2 !conversion_irq;
	endproperty
	a_drop: assert property (p_drop) else $error("irq beside a write");
	property p_stby;
		standby [*4] |-> !conversion_irq;
	endproperty
	a_stby: assert property (p_stby) else $error("irq in standby");
	property p_samp;
		$rose(sample_hold) |-> (sample_hold [*8]) or (##[0:7] (standby || cfg_wr))
			or $past(standby || cfg_wr);
	endproperty
	a_samp: assert property (p_samp) else $error("sample phase cut short");
	property p_msb;
		$fell(sample_hold) && !standby |-> ##[0:2] trial_code == 8'h80;
	endproperty
	a_msb: assert property (p_msb) else $error("first trial not msb");
	property p_rdbk;
		bus_wr && (bus_addr == 16'hff9a || bus_addr == 16'hff9b) ##2
		bus_rd && bus_addr == $past(bus_addr, 2) |=> bus_rdata == $past(bus_wdata, 3);
	endproperty
	a_rdbk: assert property (p_rdbk) else $error("readback differs");
endmodule
bind adcp_top adcp_top_chk u_chk (.clk(clk), .nrst(nrst), .bus_addr(bus_addr),
	.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
	.standby(standby), .analog_sel(analog_sel), .sample_hold(sample_hold),
	.trial_code(trial_code), .conversion_irq(conversion_irq));
`default_nettype wire

// >>> tb/adcp_afe_model.sv
// analog front end model: held input against the trial code
`timescale 1ns/1ns
`default_nettype none
module adcp_afe_model
(
	// clock
	input wire logic       clk,
	// converter side
	input wire logic       sample_hold,
	input wire logic [7:0] trial_code,
	output logic           cmp_above,
	// input and reference in millivolts
	input wire integer     vin_mv,
	input wire integer     vref_mv
);
	// ----------------------------------------
	// sample, hold and compare
	// ----------------------------------------
	int         code;
	logic [7:0] held = 8'h00;
	assign code = (vin_mv * 256 + vref_mv / 2) / vref_mv;
	// hold while resolving; later input changes are not seen
	always @(posedge clk)
		if (sample_hold)
			held <= (code > 255) ? 8'hff : code[7:0];
	assign cmp_above = trial_code <= held;
endmodule
`default_nettype wire

// >>> tb/test_adcp_top.sv
// self-checking bench for the converter control
`timescale 1ns/1ns
`default_nettype none
module test_adcp_top
	import adcp_pkg::*;
;
	// ----------------------------------------
	// stimulus, tasks and sequence
	// ----------------------------------------
	logic        clk = 1'b0, nrst = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, standby = 1'b0;
	logic [15:0] bus_addr = 16'h0000;
	logic [7:0]  bus_wdata = 8'h00, bus_rdata, trial_code;
	logic        cmp_above, sample_hold, conversion_irq;
	logic [2:0]  analog_sel;
	int          n_fail = 0, checked = 0, k;
	// compare mode, threshold, irq count in two conversions (input is code 5a)
	logic [7:0]  tab [6][3] = '{'{8'h80, 8'h50, 8'h01}, '{8'h80, 8'h5a, 8'h01},
		'{8'h80, 8'h5b, 8'h00}, '{8'hc0, 8'h5a, 8'h00}, '{8'hc0, 8'h5b, 8'h01},
		'{8'h00, 8'hff, 8'h02}};

	always #5 clk = ~clk;

	adcp_top DUT (.clk(clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .standby(standby),
		.cmp_above(cmp_above), .analog_sel(analog_sel), .sample_hold(sample_hold),
		.trial_code(trial_code), .conversion_irq(conversion_irq));
	adcp_afe_model m_afe (.clk(clk), .sample_hold(sample_hold), .trial_code(trial_code),
		.cmp_above(cmp_above), .vin_mv(1760), .vref_mv(5000));

	task check(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// strobe for one cycle, then one idle cycle so no strobe is set twice at an edge
	task wr(input logic [15:0] a, input logic [7:0] d);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		@(negedge clk);
		check(bus_rdata, e);
		@(posedge clk);
	endtask
	// count irq pulses over a bounded window
	task cnt(input int n, input logic [7:0] e);
		k = 0;
		repeat (n) @(posedge clk) if (conversion_irq === 1'b1) k++;
		check(k[7:0], e);
	endtask
	task end_of_test;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 5; i++)
			rd(16'hff98 + 16'(i), 8'h00);
		rd(16'h0000, 8'h00);
		wr(16'hff9b, 8'ha5);
		rd(16'hff9b, 8'ha5);
		wr(16'hff99, 8'h04);
		@(negedge clk);
		check({5'h00, analog_sel}, 8'h04);
		@(posedge clk);
		for (int i = 0; i < 6; i++)
		begin
			wr(16'hff98, 8'h00);
			wr(16'hff9a, tab[i][0]);
			wr(16'hff9b, tab[i][1]);
			wr(16'hff98, 8'h80);
			cnt(320, tab[i][2]);
		end
		repeat (100) @(posedge clk);
		wr(16'hff99, 8'h01);
		cnt(130, 8'h00);
		cnt(40, 8'h01);
		rd(16'hff9c, 8'h5a);
		wr(16'hff9c, 8'h33);
		rd(16'hff9c, 8'h5a);
		standby <= 1'b1;
		cnt(320, 8'h00);
		standby <= 1'b0;
		// channel write landing on the edge that sees the conversion end
		repeat (145) @(posedge clk);
		wr(16'hff99, 8'h01);
		cnt(140, 8'h00);
		cnt(20, 8'h01);
		end_of_test();
	end
endmodule
`default_nettype wire
